/* logic/vaac_pkg.sv */
// Package for the vector axis address counters: widths, reset values, carriers.
// Assumes a single 50 MHz board clock and a synchronous active-low reset.
package vaac_pkg;

  localparam int unsigned VERT_W       = 12;
  localparam int unsigned PIX_W        = 5;
  localparam int unsigned WORD_W       = 8;
  localparam int unsigned DBUS_W       = 16;
  localparam int unsigned MP_W         = 5;
  localparam int unsigned PIPE_DEPTH   = 2;
  localparam int unsigned SCISSOR_BITS = 3;
  localparam logic [4:0]  PIX_MAX      = 5'h13;
  localparam logic [4:0]  PIX_MIN      = 5'h00;
  localparam int unsigned WORD_LSB     = 8;
  localparam int unsigned DIR_H_BIT    = 0;
  localparam int unsigned DIR_V_BIT    = 1;
  localparam logic [11:0] VERT_RST     = 12'h000;
  localparam logic [4:0]  PIX_RST      = 5'h00;
  localparam logic [7:0]  WORD_RST     = 8'h00;
  localparam logic [2:0]  SELFTEST_VAL = 3'h0;
  localparam logic [3:0]  ADDR_VPOS    = 4'h0;
  localparam logic [3:0]  ADDR_VDELTA  = 4'h1;
  localparam logic [3:0]  ADDR_HORIZ   = 4'h2;
  localparam logic [3:0]  ADDR_AXIS    = 4'h3;

  typedef struct packed {
    logic [VERT_W-1:0] vert_addr;
    logic [PIX_W-1:0]  pix_addr;
    logic [WORD_W-1:0] word_addr;
  } vaac_addr_t;

  typedef struct packed {
    logic [VERT_W-1:0]     vpos_r;
    logic [VERT_W-1:0]     vdelta_r;
    logic [PIX_W-1:0]      pix_r;
    logic [WORD_W-1:0]     word_r;
    logic [PIX_W-1:0]      pix_buf_r;
    logic [WORD_W-1:0]     word_buf_r;
    logic                  hdir_n_r;
    logic                  vdir_n_r;
    vaac_addr_t [PIPE_DEPTH-1:0] pipe_r;
    logic [MP_W-1:0]       mp_d_r;
    logic                  vrq_d_r;
    logic [1:0]            mode_d1_r;
    logic [1:0]            mode_d2_r;
    logic [DBUS_W-1:0]     rdata_r;
  } vaac_state_t;

endpackage

/* logic/vaac_top.sv */
// Vertical and horizontal address counters of the raster vector generator.
// Assumes firmware on a plain register port and a microcoded state controller
// driving active-low enables; inputs are synchronous to I_MCLK.
// Functional notes
// (R1) Two twelve-bit vertical counters, bus loadable/readable
// (R2) Firmware reads vertical counters only when idle
// (R3) Position counts when enabled, direction from sign
// (R4) Delta has own enable, shares direction
// (R5) Shared vertical bus, select picks driver
// (R6) Idle default position; read strobe drives data
// (R7) Delta read borrows bus for one cycle
// (R8) Two-cycle address pipeline, output enable gated
// (R9) Vertical in-range when top three bits zero
// (R10) Pixel counter five bits, wraps modulo 20
// (R11) Pixel carry feeds eight-bit word counter
// (R12) Horizontal in-range from word top bits
// (R13) Buffers hold last written value for reload
// (R14) Write strobe or reload loads counters
// (R15) Microcode never loads and counts pixel together
// (R16) Pixel LSB toggles, holds, or loads
// (R17) LSB carry low: 1 up, 0 down
// (R18) Pixel carry low at 13h up/00h down
// (R19) Horizontal read drives pixel plus self-test bits
// (R20) Select chooses pixel counter or mask file
// (R21) Mask/pixel, request delayed one; mode two
// (R22) Word counter on upper bits, own enable
// (R23) Direction bits from axis control data bits
// (R24) Everything clears on reset
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module vaac_top (
  input  wire logic                         I_MCLK,
  input  wire logic                         I_RESETN,
  input  wire logic [3:0]                   I_ADDR,
  input  wire logic [vaac_pkg::DBUS_W-1:0]  I_WDATA,
  input  wire logic                         I_WR,
  input  wire logic                         I_RD,
  output logic      [vaac_pkg::DBUS_W-1:0]  O_RDATA,
  input  wire logic                         I_VERT_COUNT_ENABLE_N,
  input  wire logic                         I_VERT_DELTA_ENABLE_N,
  input  wire logic                         I_VERT_BUS_SELECT,
  input  wire logic                         I_CTRL_BUSY,
  input  wire logic                         I_HORIZ_RELOAD_N,
  input  wire logic                         I_PIXEL_COUNT_ENABLE_N,
  input  wire logic                         I_WORD_COUNT_ENABLE_N,
  input  wire logic                         I_PIXEL_OR_MASK_SELECT,
  input  wire logic [vaac_pkg::MP_W-1:0]    I_MASK_FILE_N,
  input  wire logic                         I_VIDEO_REQUEST_N,
  input  wire logic [1:0]                   I_PLANE_MODE_IN_N,
  input  wire logic                         I_ADDR_OUTPUT_ENABLE_N,
  output logic      [vaac_pkg::VERT_W-1:0]  O_VERT_ADDR_BUS_N,
  output logic      [vaac_pkg::VERT_W-1:0]  O_VERT_ADDR_BUS_OE_N,
  output logic      [vaac_pkg::PIX_W-1:0]   O_HORIZ_ADDR_BUS_N,
  output logic      [vaac_pkg::WORD_W-1:0]  O_WORD_ADDR_BUS_N,
  output logic                              O_HORIZ_ADDR_BUS_OE_N,
  output logic                              O_VERT_IN_RANGE,
  output logic                              O_HORIZ_IN_RANGE,
  output logic                              O_PIXEL_CARRY_OUT_N,
  output logic                              O_WORD_CARRY_OUT_N,
  output logic      [vaac_pkg::MP_W-1:0]    O_MASK_PIXEL_LINE_N,
  output logic                              O_VIDEO_REQUEST_N,
  output logic      [1:0]                   O_PLANE_MODE_OUT_N,
  output logic      [vaac_pkg::VERT_W-1:0]  O_VERT_BUS
);

  // ==========================================================
  // Register port decode
  vaac_pkg::vaac_state_t st_r;
  vaac_pkg::vaac_state_t st_nxt;

  logic wr_vpos;
  logic wr_vdlt;
  logic horiz_write_strobe_n;
  logic wr_axis;
  logic vert_pos_read_strobe_n;
  logic vert_delta_read_strobe_n;
  logic horiz_read_strobe_n;

  // Strobes exist only for the one cycle the port request stands
  always_comb begin
    wr_vpos                  = 1'b0;
    wr_vdlt                  = 1'b0;
    horiz_write_strobe_n     = 1'b1;
    wr_axis                  = 1'b0;
    vert_pos_read_strobe_n   = 1'b1;
    vert_delta_read_strobe_n = 1'b1;
    horiz_read_strobe_n      = 1'b1;
    case (I_ADDR)
      vaac_pkg::ADDR_VPOS: begin
        wr_vpos                = I_WR;
        vert_pos_read_strobe_n = !I_RD;
      end
      vaac_pkg::ADDR_VDELTA: begin
        wr_vdlt                  = I_WR;
        vert_delta_read_strobe_n = !I_RD;
      end
      vaac_pkg::ADDR_HORIZ: begin
        horiz_write_strobe_n = !I_WR;
        horiz_read_strobe_n  = !I_RD;
      end
      vaac_pkg::ADDR_AXIS: begin
        wr_axis = I_WR;
      end
      default: begin
      end
    endcase
  end

  // ==========================================================
  // Shared vertical bus and decodes
  logic                        vert_pick_pos;
  logic [vaac_pkg::VERT_W-1:0] vert_bus;
  logic                        vert_count_up;
  logic                        horiz_count_up;
  logic                        horiz_buffer_enable;
  logic                        horiz_counter_load_n;
  logic                        lsb_carry_n;
  logic                        pixel_carry_out_n;
  logic                        word_carry_out_n;
  logic [vaac_pkg::MP_W-1:0]   mp_src;
  logic [vaac_pkg::VERT_W-1:0] vpos_step;
  logic [vaac_pkg::VERT_W-1:0] vdelta_step;
  logic                        pix_at_end;
  logic [3:0]                  pix_upper_step;
  logic [vaac_pkg::PIX_W-1:0]  pix_load_val;
  logic                        word_at_end;
  logic [vaac_pkg::WORD_W-1:0] word_step;
  logic [vaac_pkg::WORD_W-1:0] word_load_val;

  always_comb begin
    if (I_CTRL_BUSY) begin
      vert_pick_pos = I_VERT_BUS_SELECT;                         // R5
    end else begin
      vert_pick_pos = vert_delta_read_strobe_n;                  // R6 R7
    end
  end

  // Tristate sharing becomes a multiplexer: exactly one counter on the bus
  always_comb begin
    if (vert_pick_pos) begin
      vert_bus = st_r.vpos_r;                                    // R5 R6
    end else begin
      vert_bus = st_r.vdelta_r;                                  // R5 R7
    end
  end

  assign vert_count_up  = st_r.vdir_n_r;
  assign horiz_count_up = st_r.hdir_n_r;

  assign horiz_buffer_enable  = !horiz_write_strobe_n;            // R13
  assign horiz_counter_load_n = horiz_write_strobe_n && I_HORIZ_RELOAD_N; // R14

  assign lsb_carry_n = horiz_count_up ? !st_r.pix_r[0] : st_r.pix_r[0]; // R17

  // R18: end of count in the current direction, qualified by the enable
  assign pixel_carry_out_n = !(!I_PIXEL_COUNT_ENABLE_N && pix_at_end);
  assign word_carry_out_n  = !(!I_WORD_COUNT_ENABLE_N && word_at_end);   // R22

  assign mp_src = I_PIXEL_OR_MASK_SELECT ? ~st_r.pix_r : I_MASK_FILE_N; // R20

  // ==========================================================
  // Counter step values
  // Both vertical counters follow the one vertical direction bit
  always_comb begin
    if (vert_count_up) begin
      vpos_step   = st_r.vpos_r + 12'h001;                       // R3
      vdelta_step = st_r.vdelta_r + 12'h001;                     // R4
    end else begin
      vpos_step   = st_r.vpos_r - 12'h001;                       // R3
      vdelta_step = st_r.vdelta_r - 12'h001;                     // R4
    end
  end

  // Upper pixel digit only moves on the LSB carry and skips 14h..1Fh
  always_comb begin
    if (horiz_count_up) begin
      pix_at_end = (st_r.pix_r == vaac_pkg::PIX_MAX);            // R18
      if (st_r.pix_r[4:1] == vaac_pkg::PIX_MAX[4:1]) begin
        pix_upper_step = 4'h0;                                   // R10
      end else begin
        pix_upper_step = st_r.pix_r[4:1] + 4'h1;
      end
    end else begin
      pix_at_end = (st_r.pix_r == vaac_pkg::PIX_MIN);            // R18
      if (st_r.pix_r[4:1] == 4'h0) begin
        pix_upper_step = vaac_pkg::PIX_MAX[4:1];                 // R10
      end else begin
        pix_upper_step = st_r.pix_r[4:1] - 4'h1;
      end
    end
  end

  // Word counter shares the horizontal direction bit
  always_comb begin
    if (horiz_count_up) begin
      word_at_end = (st_r.word_r == 8'hFF);
      word_step   = st_r.word_r + 8'h01;                         // R22
    end else begin
      word_at_end = (st_r.word_r == 8'h00);
      word_step   = st_r.word_r - 8'h01;                         // R22
    end
  end

  // A firmware write beats the buffer: the counter takes the new value at once
  always_comb begin
    if (horiz_buffer_enable) begin
      pix_load_val  = I_WDATA[vaac_pkg::PIX_W-1:0];              // R14
      word_load_val = I_WDATA[vaac_pkg::WORD_LSB +: vaac_pkg::WORD_W];
    end else begin
      pix_load_val  = st_r.pix_buf_r;                            // R13
      word_load_val = st_r.word_buf_r;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // R1 R3 R4
    // A counter write beats its count enable in the same cycle
    if (wr_vpos) begin
      st_nxt.vpos_r = I_WDATA[vaac_pkg::VERT_W-1:0];
    end else if (!I_VERT_COUNT_ENABLE_N) begin
      st_nxt.vpos_r = vpos_step;
    end
    if (wr_vdlt) begin
      st_nxt.vdelta_r = I_WDATA[vaac_pkg::VERT_W-1:0];
    end else if (!I_VERT_DELTA_ENABLE_N) begin
      st_nxt.vdelta_r = vdelta_step;
    end

    // R23
    if (wr_axis) begin
      st_nxt.hdir_n_r = I_WDATA[vaac_pkg::DIR_H_BIT];
      st_nxt.vdir_n_r = I_WDATA[vaac_pkg::DIR_V_BIT];
    end

    // R13 R22
    if (horiz_buffer_enable) begin
      st_nxt.pix_buf_r  = I_WDATA[vaac_pkg::PIX_W-1:0];
      st_nxt.word_buf_r = I_WDATA[vaac_pkg::WORD_LSB +: vaac_pkg::WORD_W];
    end

    // R10 R16 R17
    // Load wins should microcode ever overlap load and count
    if (!horiz_counter_load_n) begin
      st_nxt.pix_r = pix_load_val;
    end else if (!I_PIXEL_COUNT_ENABLE_N) begin
      st_nxt.pix_r[0] = !st_r.pix_r[0];
      if (!lsb_carry_n) begin
        st_nxt.pix_r[4:1] = pix_upper_step;
      end
    end

    // R11 R22
    if (!horiz_counter_load_n) begin
      st_nxt.word_r = word_load_val;
    end else if (!I_WORD_COUNT_ENABLE_N && !pixel_carry_out_n) begin
      st_nxt.word_r = word_step;
    end

    // R8
    st_nxt.pipe_r[0].vert_addr = vert_bus;
    st_nxt.pipe_r[0].pix_addr  = st_r.pix_r;
    st_nxt.pipe_r[0].word_addr = st_r.word_r;
    for (int s = 1; s < vaac_pkg::PIPE_DEPTH; s++) begin
      st_nxt.pipe_r[s] = st_r.pipe_r[s-1];
    end

    // R21
    st_nxt.mp_d_r    = mp_src;
    st_nxt.vrq_d_r   = I_VIDEO_REQUEST_N;
    st_nxt.mode_d1_r = I_PLANE_MODE_IN_N;
    st_nxt.mode_d2_r = st_r.mode_d1_r;

    // R6 R19 R22
    // Read data stand for one cycle and are zero otherwise
    st_nxt.rdata_r = '0;
    if (!vert_pos_read_strobe_n) begin
      st_nxt.rdata_r[vaac_pkg::VERT_W-1:0] = vert_bus;
    end
    if (!vert_delta_read_strobe_n) begin
      st_nxt.rdata_r[vaac_pkg::VERT_W-1:0] = vert_bus;           // R7
    end
    if (!horiz_read_strobe_n) begin
      st_nxt.rdata_r[vaac_pkg::PIX_W-1:0] = st_r.pix_r;
      st_nxt.rdata_r[7:5] = vaac_pkg::SELFTEST_VAL;
      st_nxt.rdata_r[vaac_pkg::WORD_LSB +: vaac_pkg::WORD_W] = st_r.word_r;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      st_r <= '0;                                                 // R24
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Scissoring decodes: memory cycles only while the top bits are zero
  logic vert_in_range;
  logic horiz_in_range;

  assign vert_in_range  = (vert_bus[11:9] == 3'h0);              // R9
  assign horiz_in_range = (st_r.word_r[7:5] == 3'h0);            // R12

  // ==========================================================
  // Register port read data
  assign O_RDATA               = st_r.rdata_r;

  // ==========================================================
  // Address buses toward the bit planes, inverted; O_VERT_BUS and the output enables pass through as is
  assign O_VERT_BUS            = vert_bus;
  assign O_VERT_ADDR_BUS_N     = ~st_r.pipe_r[1].vert_addr;
  assign O_VERT_ADDR_BUS_OE_N  = {vaac_pkg::VERT_W{I_ADDR_OUTPUT_ENABLE_N}}; // R8
  assign O_HORIZ_ADDR_BUS_N    = ~st_r.pipe_r[1].pix_addr;
  assign O_WORD_ADDR_BUS_N     = ~st_r.pipe_r[1].word_addr;
  assign O_HORIZ_ADDR_BUS_OE_N = I_ADDR_OUTPUT_ENABLE_N;          // R8

  // ==========================================================
  // Scissoring and carries toward the counter control
  assign O_VERT_IN_RANGE       = vert_in_range;                   // R9
  assign O_HORIZ_IN_RANGE      = horiz_in_range;                  // R12
  assign O_PIXEL_CARRY_OUT_N   = pixel_carry_out_n;               // R18
  assign O_WORD_CARRY_OUT_N    = word_carry_out_n;

  // ==========================================================
  // Delayed mask/pixel lines and plane controls
  assign O_MASK_PIXEL_LINE_N   = st_r.mp_d_r;
  assign O_VIDEO_REQUEST_N     = st_r.vrq_d_r;
  assign O_PLANE_MODE_OUT_N    = st_r.mode_d2_r;

endmodule

/* tb/vaac_props.sv */
// Checker for vaac_top output timing.
// Assumes a bind onto vaac_top and a synchronous active-low reset.
`timescale 1ns/1ns
module vaac_props (
  input wire logic        I_MCLK,
  input wire logic        I_RESETN,
  input wire logic [3:0]  I_ADDR,
  input wire logic        I_RD,
  input wire logic [15:0] O_RDATA,
  input wire logic [11:0] O_VERT_BUS,
  input wire logic [11:0] O_VERT_ADDR_BUS_N,
  input wire logic        O_VERT_IN_RANGE,
  input wire logic        O_HORIZ_IN_RANGE,
  input wire logic [4:0]  O_HORIZ_ADDR_BUS_N,
  input wire logic [7:0]  O_WORD_ADDR_BUS_N,
  input wire logic        O_PIXEL_CARRY_OUT_N,
  input wire logic        I_VIDEO_REQUEST_N,
  input wire logic        O_VIDEO_REQUEST_N,
  input wire logic        I_PIXEL_OR_MASK_SELECT,
  input wire logic [4:0]  I_MASK_FILE_N,
  input wire logic [4:0]  O_MASK_PIXEL_LINE_N,
  input wire logic [1:0]  I_PLANE_MODE_IN_N,
  input wire logic [1:0]  O_PLANE_MODE_OUT_N,
  input wire logic        I_ADDR_OUTPUT_ENABLE_N,
  input wire logic [11:0] O_VERT_ADDR_BUS_OE_N,
  input wire logic        O_HORIZ_ADDR_BUS_OE_N,
  input wire logic        O_WORD_CARRY_OUT_N
);
  // ========
  // Properties
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_vert_read; I_RD && (I_ADDR < 4'h2); endsequence
  sequence s_live2; $past(I_RESETN) && $past(I_RESETN, 2); endsequence
  a_vert_range: assert property (O_VERT_IN_RANGE == (O_VERT_BUS[11:9] == 3'h0))
    else $error("vert range wrong");
  a_vert_pipe: assert property (s_live2 |-> O_VERT_ADDR_BUS_N == ~$past(O_VERT_BUS, 2))
    else $error("vert pipe wrong");
  a_vert_read: assert property (s_vert_read |=> O_RDATA == {4'h0, $past(O_VERT_BUS)})
    else $error("vert read wrong");
  a_rdata_quiet: assert property (!I_RD |=> O_RDATA == 16'h0000)
    else $error("read data not idle");
  a_pixel_bound: assert property (~O_HORIZ_ADDR_BUS_N <= 5'h13)
    else $error("pixel out of range");
  a_horiz_range: assert property (s_live2 |->
    $past(O_HORIZ_IN_RANGE, 2) == (~O_WORD_ADDR_BUS_N[7:5] == 3'h0))
    else $error("horiz range wrong");
  a_pixel_carry: assert property (!O_PIXEL_CARRY_OUT_N |->
    ##2 (O_HORIZ_ADDR_BUS_N == 5'h0C || O_HORIZ_ADDR_BUS_N == 5'h1F))
    else $error("pixel carry wrong");
  a_request_delay: assert property ($past(I_RESETN) |->
    O_VIDEO_REQUEST_N == $past(I_VIDEO_REQUEST_N))
    else $error("request delay wrong");
  a_mode_delay: assert property (s_live2 |-> O_PLANE_MODE_OUT_N == $past(I_PLANE_MODE_IN_N, 2))
    else $error("mode delay wrong");
  a_oe_follow: assert property (O_VERT_ADDR_BUS_OE_N == {12{I_ADDR_OUTPUT_ENABLE_N}} &&
    O_HORIZ_ADDR_BUS_OE_N == I_ADDR_OUTPUT_ENABLE_N)
    else $error("output enable wrong");
  a_mask_lines: assert property ($past(I_RESETN) && !$past(I_PIXEL_OR_MASK_SELECT) |->
    O_MASK_PIXEL_LINE_N == $past(I_MASK_FILE_N))
    else $error("mask lines wrong");
  a_pixel_lines: assert property (s_live2 ##0 $past(I_PIXEL_OR_MASK_SELECT, 2) |->
    $past(O_MASK_PIXEL_LINE_N) == O_HORIZ_ADDR_BUS_N)
    else $error("pixel lines wrong");
  a_word_carry: assert property (!O_WORD_CARRY_OUT_N |->
    ##2 (O_WORD_ADDR_BUS_N == 8'h00 || O_WORD_ADDR_BUS_N == 8'hFF))
    else $error("word carry wrong");
endmodule
bind vaac_top vaac_props vaac_props_inst (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_VERT_BUS(O_VERT_BUS), .O_VERT_ADDR_BUS_N(O_VERT_ADDR_BUS_N),
  .O_VERT_IN_RANGE(O_VERT_IN_RANGE), .O_HORIZ_IN_RANGE(O_HORIZ_IN_RANGE),
  .O_HORIZ_ADDR_BUS_N(O_HORIZ_ADDR_BUS_N), .O_WORD_ADDR_BUS_N(O_WORD_ADDR_BUS_N),
  .O_PIXEL_CARRY_OUT_N(O_PIXEL_CARRY_OUT_N), .I_VIDEO_REQUEST_N(I_VIDEO_REQUEST_N),
  .O_VIDEO_REQUEST_N(O_VIDEO_REQUEST_N), .I_PIXEL_OR_MASK_SELECT(I_PIXEL_OR_MASK_SELECT),
  .I_MASK_FILE_N(I_MASK_FILE_N), .O_MASK_PIXEL_LINE_N(O_MASK_PIXEL_LINE_N),
  .I_PLANE_MODE_IN_N(I_PLANE_MODE_IN_N), .O_PLANE_MODE_OUT_N(O_PLANE_MODE_OUT_N),
  .I_ADDR_OUTPUT_ENABLE_N(I_ADDR_OUTPUT_ENABLE_N), .O_VERT_ADDR_BUS_OE_N(O_VERT_ADDR_BUS_OE_N),
  .O_HORIZ_ADDR_BUS_OE_N(O_HORIZ_ADDR_BUS_OE_N), .O_WORD_CARRY_OUT_N(O_WORD_CARRY_OUT_N));

/* tb/vaac_ctl_model.sv */
// State controller model: mode 0 idle, 1 position, 2 delta, 3 pixel and word, 4 reload, 5 pixel.
// Assumes the bench changes the mode just after a rising edge.
`timescale 1ns/1ns
module vaac_ctl_model (
  input  wire logic [2:0] i_mode,
  output logic            o_busy,
  output logic            o_vsel,
  output logic            o_vcen_n,
  output logic            o_vden_n,
  output logic            o_pen_n,
  output logic            o_wen_n,
  output logic            o_rel_n
);
  // ========
  // Control decode
  assign o_busy   = (i_mode != 3'h0);
  assign o_vsel   = (i_mode != 3'h2);
  assign o_vcen_n = (i_mode != 3'h1);
  assign o_vden_n = (i_mode != 3'h2);
  assign o_pen_n  = !(i_mode == 3'h3 || i_mode == 3'h5);
  assign o_wen_n  = (i_mode != 3'h3);
  assign o_rel_n  = (i_mode != 3'h4);
endmodule

/* tb/testbench.sv */
// Self-checking bench for vaac_top with firmware traffic and controller modes.
// Assumes vaac_props is bound and vaac_ctl_model stands for the controller.
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [4:0]  mask_n = 5'h1F;
  logic [1:0]  pm_n = 2'h3;
  logic        vrq_n = 1'b1;
  logic        sel = 1'b1;
  logic        oe_n = 1'b1;
  logic        busy, vsel, vcen_n, vden_n, pen_n, wen_n, rel_n;
  logic [15:0] rdata;
  logic [15:0] exp_q[$];
  logic        rd_pend = 1'b0;
  int          failures = 0;
  int          check_count = 0;
  logic [11:0] v, d;
  logic [7:0]  w;
  vaac_ctl_model vaac_ctl_model_inst (.i_mode(mode), .o_busy(busy), .o_vsel(vsel),
    .o_vcen_n(vcen_n), .o_vden_n(vden_n), .o_pen_n(pen_n), .o_wen_n(wen_n), .o_rel_n(rel_n));
  vaac_top vaac_top_inst (.I_MCLK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_VERT_COUNT_ENABLE_N(vcen_n),
    .I_VERT_DELTA_ENABLE_N(vden_n), .I_VERT_BUS_SELECT(vsel), .I_CTRL_BUSY(busy),
    .I_HORIZ_RELOAD_N(rel_n), .I_PIXEL_COUNT_ENABLE_N(pen_n), .I_WORD_COUNT_ENABLE_N(wen_n),
    .I_PIXEL_OR_MASK_SELECT(sel), .I_MASK_FILE_N(mask_n), .I_VIDEO_REQUEST_N(vrq_n),
    .I_PLANE_MODE_IN_N(pm_n), .I_ADDR_OUTPUT_ENABLE_N(oe_n), .O_VERT_ADDR_BUS_N(),
    .O_VERT_ADDR_BUS_OE_N(), .O_HORIZ_ADDR_BUS_N(), .O_WORD_ADDR_BUS_N(),
    .O_HORIZ_ADDR_BUS_OE_N(), .O_VERT_IN_RANGE(), .O_HORIZ_IN_RANGE(),
    .O_PIXEL_CARRY_OUT_N(), .O_WORD_CARRY_OUT_N(), .O_MASK_PIXEL_LINE_N(),
    .O_VIDEO_REQUEST_N(), .O_PLANE_MODE_OUT_N(), .O_VERT_BUS());
  // ========
  // Clock, checks and bus tasks
  always #10 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED read data expected %h seen %h", exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic run(input logic [2:0] m, input int n);
    @(posedge clk);
    mode <= m;
    repeat (n) @(posedge clk);
    mode <= 3'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_pend) check(rdata, exp_q.pop_front());
    rd_pend = rd;
  end
  always @(posedge clk) begin
    mask_n <= 5'($urandom);
    pm_n <= 2'($urandom);
    vrq_n <= 1'($urandom);
    sel <= 1'($urandom);
    oe_n <= 1'($urandom);
  end
  // ========
  // Scenarios
  initial begin
    void'($urandom(32'h01C6));
    v = 12'($urandom);
    d = 12'($urandom);
    w = 8'($urandom);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(4'h2, 16'h0000);
    wr_reg(4'h3, 16'h0003);
    wr_reg(4'h0, {4'h0, v});
    wr_reg(4'h1, {4'h0, d});
    rd_reg(4'h1, {4'h0, d});
    rd_reg(4'h0, {4'h0, v});
    run(3'h1, 3);
    run(3'h2, 5);
    rd_reg(4'h0, {4'h0, v + 12'h003});
    rd_reg(4'h1, {4'h0, d + 12'h005});
    wr_reg(4'h3, 16'h0000);
    run(3'h1, 2);
    rd_reg(4'h0, {4'h0, v + 12'h001});
    rd_reg(4'hF, 16'h0000);
    wr_reg(4'h3, 16'h0001);
    wr_reg(4'h2, {w, 8'h12});
    run(3'h3, 2);
    rd_reg(4'h2, {w + 8'h01, 8'h00});
    run(3'h4, 1);
    rd_reg(4'h2, {w, 8'h12});
    run(3'h5, 3);
    rd_reg(4'h2, {w, 8'h01});
    wr_reg(4'h3, 16'h0000);
    run(3'h3, 2);
    rd_reg(4'h2, {w - 8'h01, 8'h13});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(4'h2, 16'h0000);
    rd_reg(4'h1, 16'h0000);
    repeat (3) @(posedge clk);
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
